//--- rtl/reset_power_on_controller.sv
// Reset and power-on controller: reset sources, power-on sequencer, watchdog and registers
//
// What this block does
// RULE1 - Any reset source causes a system reset
// RULE2 - Hardware resets run power-on sequence; software not
// RULE3 - Leave reset with init registers, vector 0x0000
// RULE4 - Sequence: power then clock stabilization, then run
// RULE5 - Power stabilization lasts 4.6 ms
// RULE6 - Load clock, wait 2048 clocks plus 5 slow
// RULE7 - Three thresholds; option picks reset or flag
// RULE8 - Maximum option resets at or below 3.3 V
// RULE9 - High option resets 2.4 V, flags 3.3 V
// RULE10 - Medium resets 1.8 V, flags 2.4 V; low only resets
// RULE11 - Writing 0x5a to watchdog clear restarts timer
// RULE12 - Watchdog resets after 256 prescaled ticks
// RULE13 - Prescaler divides 16 kHz by 4/8/16/32
// RULE14 - Always option counts in every power mode
// RULE15 - Enable option counts only in normal mode
// RULE16 - Disable option never counts nor resets
// RULE17 - Direct pin: low resets until pin high
// RULE18 - De-bounced pin: reset after 8 ms low
// RULE19 - Pin is reset, de-bounced reset, or GPIO
// RULE20 - Two consecutive 0x01 writes cause software reset
// RULE21 - Clock option selects five sources; unused pins GPIO
// RULE22 - Cause flags record supply, watchdog or pin reset
// RULE23 - Mid/high flags show present supply comparison
// RULE24 - Software request is bit 0, others zero
// RULE25 - Other write between cancels pending request
// RULE26 - CPU reset held until sequence or pulse completes
`timescale 1ns/100ps
module reset_power_on_controller
    import rst_ctrl_pkg::*;
#(
    parameter int PWR_STAB_CYCLES = rst_ctrl_pkg::PWR_STAB_CYC,
    parameter int DEBOUNCE_CYCLES = rst_ctrl_pkg::DEBOUNCE_CYC,
    parameter int SLOW_CYCLES = rst_ctrl_pkg::SLOW_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Build-time options
    input wire rst_ctrl_pkg::detect_opt_t detect_opt_i,
    input wire rst_ctrl_pkg::pin_opt_t pin_opt_i,
    input wire rst_ctrl_pkg::wdog_opt_t wdog_opt_i,
    input wire logic [1:0] wdog_div_sel_i,
    input wire rst_ctrl_pkg::clksrc_t clksrc_opt_i,
    // Supply comparators, high while supply at or below threshold
    input wire logic supply_le_1v8_i,
    input wire logic supply_le_2v4_i,
    input wire logic supply_le_3v3_i,
    // Shared reset pin, active low
    input wire logic shared_reset_pin_n_i,
    // Power mode and oscillator ticks
    input wire rst_ctrl_pkg::pmode_t pmode_i,
    input wire logic osc_tick_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Core control
    output logic cpu_rst_o,
    output logic [15:0] fetch_addr_o,
    output rst_ctrl_pkg::clksrc_t clksrc_o,
    output logic osc_start_o,
    output logic osc_pins_gpio_o,
    output logic shared_pin_gpio_o
);
    import rst_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset sources
    logic supply_rst;
    logic pin_rst;
    logic wdog_rst;
    logic sw_rst;
    logic hw_rst;
    logic [31:0] deb_cnt;

    // Supply option picks which comparator resets
    always_comb begin
        unique case (detect_opt_i)
            DETECT_MAXIMUM: supply_rst = supply_le_3v3_i; // see RULE8
            DETECT_HIGH: supply_rst = supply_le_2v4_i; // see RULE9
            default: supply_rst = supply_le_1v8_i; // see RULE10
        endcase
    end

    // De-bounce counter: any high sample restarts it, so short pulses vanish
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || shared_reset_pin_n_i || pin_opt_i != PIN_RESET_DEBOUNCE) begin
            deb_cnt <= 32'h0;
        end else if (deb_cnt < DEBOUNCE_CYCLES) begin
            deb_cnt <= deb_cnt + 32'h1; // see RULE18
        end
    end

    // Pin reset by option; GPIO use never resets
    always_comb begin
        unique case (pin_opt_i)
            PIN_RESET_DIRECT: pin_rst = !shared_reset_pin_n_i; // see RULE17
            PIN_RESET_DEBOUNCE: pin_rst = (deb_cnt >= DEBOUNCE_CYCLES); // see RULE18
            default: pin_rst = 1'b0; // see RULE19
        endcase
    end

    assign shared_pin_gpio_o = (pin_opt_i == PIN_GPIO); // see RULE19
    assign hw_rst = supply_rst | pin_rst | wdog_rst; // see RULE1

    ////////////////////////////////////////////////////////////////////////////
    // Slow oscillator tick and watchdog
    logic [15:0] slow_cnt;
    logic slow_tick;
    logic [4:0] pre_cnt;
    logic [8:0] wdog_cnt;
    logic wdog_run;
    logic wd_clear;
    seq_state_t state;

    // Slow oscillator modelled as a divider of the system clock
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || slow_cnt == 16'(SLOW_CYCLES - 1)) begin
            slow_cnt <= 16'h0;
        end else begin
            slow_cnt <= slow_cnt + 16'h1;
        end
    end
    assign slow_tick = (slow_cnt == 16'(SLOW_CYCLES - 1));

    // Prescaler terminal count 3, 7, 15 or 31, dividing by 4, 8, 16 or 32
    function automatic logic [4:0] pre_last(input logic [1:0] sel);
        pre_last = 5'((6'h4 << sel) - 6'h1);
    endfunction

    // Running depends on option and power mode
    always_comb begin
        unique case (wdog_opt_i)
            WDOG_ALWAYS: wdog_run = 1'b1; // see RULE14
            WDOG_ENABLE: wdog_run = (pmode_i == PMODE_NORMAL); // see RULE15
            default: wdog_run = 1'b0; // see RULE16
        endcase
    end

    // Watchdog counts only while running firmware; restarts on each reset
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || state != ST_RUN || wd_clear || !wdog_run) begin
            pre_cnt <= 5'h0;
        end else if (slow_tick) begin
            pre_cnt <= (pre_cnt == pre_last(wdog_div_sel_i)) ? 5'h0 : pre_cnt + 5'h1; // see RULE13
        end
    end

    // Idle or stop in enable mode freezes the count rather than clearing it
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || state != ST_RUN || wd_clear) begin
            wdog_cnt <= 9'h0; // see RULE11
        end else if (wdog_run && slow_tick && pre_cnt == pre_last(wdog_div_sel_i)
                     && wdog_cnt < 9'(WDT_TICKS)) begin
            wdog_cnt <= wdog_cnt + 9'h1; // see RULE12
        end
    end
    assign wdog_rst = wdog_run && (wdog_cnt == 9'(WDT_TICKS)); // see RULE12

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    logic wr_flags;
    logic wr_swrst;
    logic sw_pending;
    logic sw_req_bit;
    logic [7:0] flag_reg;

    assign avs_waitrequest_o = 1'b0; // Every access completes in its first cycle
    assign wr_swrst = avs_write_i && avs_address_i == ADDR_SWRST;
    assign wr_flags = avs_write_i && avs_address_i == ADDR_FLAGS;
    assign wd_clear = avs_write_i && avs_address_i == ADDR_WDCLR
                      && avs_writedata_i[7:0] == WDT_CLEAR_KEY; // see RULE11
    assign sw_rst = wr_swrst && sw_pending && avs_writedata_i[7:0] == SWRST_KEY; // see RULE20

    // First key write arms; any other value disarms
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || state != ST_RUN) begin
            sw_pending <= 1'b0;
        end else if (wr_swrst) begin
            sw_pending <= (avs_writedata_i[7:0] == SWRST_KEY) && !sw_pending; // see RULE25
        end
    end

    // Request bit reads back what was last written, cleared by any reset
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || state != ST_RUN) begin
            sw_req_bit <= 1'b0; // see RULE24
        end else if (wr_swrst) begin
            sw_req_bit <= avs_writedata_i[0];
        end
    end

    // Cause flags set by hardware reset; live supply flags per option
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            flag_reg <= 8'h00;
        end else begin
            if (hw_rst) begin
                flag_reg[FLAG_SUPPLY_BIT] <= supply_rst; // see RULE22
                flag_reg[FLAG_WDOG_BIT] <= wdog_rst;
                flag_reg[FLAG_PIN_BIT] <= pin_rst;
            end
            flag_reg[FLAG_MID_BIT] <= (detect_opt_i == DETECT_MEDIUM) && supply_le_2v4_i; // see RULE23
            flag_reg[FLAG_HIGH_BIT] <= (detect_opt_i == DETECT_HIGH) && supply_le_3v3_i; // see RULE7
        end
    end

    // Read data decoded in the same cycle the read is accepted
    always_comb begin
        unique case (avs_address_i)
            ADDR_FLAGS: avs_readdata_o = {24'h0, flag_reg};
            ADDR_SWRST: avs_readdata_o = {31'h0, sw_req_bit};
            default: avs_readdata_o = 32'h0; // Clear register and unmapped read zero
        endcase
        if (!avs_read_i) begin
            avs_readdata_o = 32'h0; // Idle bus shows zero
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-on sequencer
    logic [31:0] seq_cnt;
    logic [2:0] slow_seen;
    seq_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_HOLD: if (!hw_rst) next_state = ST_PWR_STAB; // see RULE4
            ST_PWR_STAB: if (seq_cnt >= 32'(PWR_STAB_CYCLES - 1)) next_state = ST_CLK_STAB; // see RULE5
            ST_CLK_STAB: if (seq_cnt >= 32'(CLK_STAB_OSC) && slow_seen >= 3'(CLK_STAB_SLOW))
                next_state = ST_RUN; // see RULE6
            ST_SW_PULSE: next_state = ST_RUN; // see RULE2
            ST_RUN: if (sw_rst) next_state = ST_SW_PULSE; // see RULE20
        endcase
        if (hw_rst) begin
            next_state = ST_HOLD; // see RULE2
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state <= ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Phase counter: system cycles in power phase, oscillator ticks in clock phase
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || state != next_state) begin
            seq_cnt <= 32'h0;
        end else if (state == ST_PWR_STAB || (state == ST_CLK_STAB && osc_tick_i)) begin
            seq_cnt <= seq_cnt + 32'h1;
        end
    end

    // Slow ticks count only once the oscillator count is done, so the two waits add up
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || state != ST_CLK_STAB) begin
            slow_seen <= 3'h0;
        end else if (slow_tick && seq_cnt >= 32'(CLK_STAB_OSC)
                     && slow_seen < 3'(CLK_STAB_SLOW)) begin
            slow_seen <= slow_seen + 3'h1; // see RULE6
        end
    end

    // Clock source latched as the power phase ends
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            clksrc_o <= CLKSRC_FAST_RC;
            osc_start_o <= 1'b0;
        end else begin
            if (state == ST_PWR_STAB && next_state == ST_CLK_STAB) begin
                clksrc_o <= clksrc_opt_i; // see RULE21
            end
            osc_start_o <= (next_state == ST_CLK_STAB || next_state == ST_RUN
                            || next_state == ST_SW_PULSE);
        end
    end

    // Fast RC needs no oscillator pins; every other source, external clock included, keeps them
    assign osc_pins_gpio_o = (clksrc_o == CLKSRC_FAST_RC); // see RULE21

    // CPU reset held except while running
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cpu_rst_o <= 1'b1;
            fetch_addr_o <= RESET_VECTOR;
        end else begin
            cpu_rst_o <= (next_state != ST_RUN); // see RULE26
            fetch_addr_o <= RESET_VECTOR; // see RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_sw_second;
        wr_swrst && sw_pending && avs_writedata_i[7:0] == SWRST_KEY && state == ST_RUN;
    endsequence
    property p_sw_pulse;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (s_sw_second and !hw_rst) |=> cpu_rst_o ##1 (state == ST_RUN);
    endproperty
    a_sw_pulse: assert property (p_sw_pulse) else $error("soft reset pulse wrong"); // see RULE20

    property p_hw_hold;
        @(posedge clk_sys_i) disable iff (sys_rst_i) hw_rst |=> cpu_rst_o && state == ST_HOLD;
    endproperty
    a_hw_hold: assert property (p_hw_hold) else $error("hardware reset not held"); // see RULE26

    property p_disable;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        wdog_opt_i == WDOG_DISABLE |-> wdog_cnt == 9'h0 && !wdog_rst;
    endproperty
    a_disable: assert property (p_disable) else $error("disabled watchdog reset"); // see RULE16

    property p_clear;
        @(posedge clk_sys_i) disable iff (sys_rst_i) wd_clear |=> wdog_cnt == 9'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("watchdog not cleared"); // see RULE11

    property p_max;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        detect_opt_i == DETECT_MAXIMUM && supply_le_3v3_i |-> hw_rst;
    endproperty
    a_max: assert property (p_max) else $error("maximum option missed reset"); // see RULE8

    property p_direct_pin;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        pin_opt_i == PIN_RESET_DIRECT && !shared_reset_pin_n_i |=> cpu_rst_o;
    endproperty
    a_direct_pin: assert property (p_direct_pin) else $error("direct pin no reset"); // see RULE17

    property p_gpio_pin;
        @(posedge clk_sys_i) disable iff (sys_rst_i) pin_opt_i == PIN_GPIO |-> !pin_rst;
    endproperty
    a_gpio_pin: assert property (p_gpio_pin) else $error("gpio pin reset"); // see RULE19

    property p_pwr_to_clk;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        state == ST_CLK_STAB |-> $past(state) inside {ST_PWR_STAB, ST_CLK_STAB};
    endproperty
    a_pwr_to_clk: assert property (p_pwr_to_clk) else $error("phase order wrong"); // see RULE4

    property p_run_after_clk;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        state == ST_RUN && $past(state) != ST_RUN |->
            $past(state) inside {ST_CLK_STAB, ST_SW_PULSE};
    endproperty
    a_run_after_clk: assert property (p_run_after_clk) else $error("run entered early"); // see RULE2
endmodule

//--- rtl/rst_ctrl_pkg.sv
// Constants, option encodings and register map of the reset and power-on controller
package rst_ctrl_pkg;
    // Clock rate of the system clock, kHz
    localparam int CLK_KHZ = 125000;
    // Power stabilization time in microseconds (4.6 ms) and its cycle count
    localparam int PWR_STAB_US = 4600;
    localparam int PWR_STAB_CYC = PWR_STAB_US * (CLK_KHZ / 1000);
    // De-bounce low time in milliseconds and its cycle count
    localparam int DEBOUNCE_MS = 8;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
    // Clock stabilization counts
    localparam int CLK_STAB_OSC = 2048;
    localparam int CLK_STAB_SLOW = 5;
    // Watchdog ticks between clears
    localparam int WDT_TICKS = 256;
    // Slow oscillator frequency in Hz and system cycles per slow-oscillator period
    localparam int SLOW_OSC_HZ = 16000;
    localparam int SLOW_PERIOD_CYC = (CLK_KHZ * 1000) / SLOW_OSC_HZ;
    // Reset vector
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // Register byte addresses (word aligned)
    localparam logic [3:0] ADDR_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_SWRST = 4'h4;
    localparam logic [3:0] ADDR_WDCLR = 4'h8;
    // Field positions of the flag register
    localparam int FLAG_SUPPLY_BIT = 7;
    localparam int FLAG_WDOG_BIT = 6;
    localparam int FLAG_PIN_BIT = 5;
    localparam int FLAG_MID_BIT = 2;
    localparam int FLAG_HIGH_BIT = 1;
    // Magic values
    localparam logic [7:0] WDT_CLEAR_KEY = 8'h5a;
    localparam logic [7:0] SWRST_KEY = 8'h01;

    // Supply detection options
    typedef enum logic [1:0] {
        DETECT_LOW = 2'h0,
        DETECT_MEDIUM = 2'h1,
        DETECT_HIGH = 2'h2,
        DETECT_MAXIMUM = 2'h3
    } detect_opt_t;
    // Shared pin use
    typedef enum logic [1:0] {
        PIN_RESET_DEBOUNCE = 2'h0,
        PIN_RESET_DIRECT = 2'h1,
        PIN_GPIO = 2'h2
    } pin_opt_t;
    // Watchdog options
    typedef enum logic [1:0] {
        WDOG_ALWAYS = 2'h0,
        WDOG_ENABLE = 2'h1,
        WDOG_DISABLE = 2'h2
    } wdog_opt_t;
    // Power modes
    typedef enum logic [1:0] {
        PMODE_NORMAL = 2'h0,
        PMODE_IDLE = 2'h1,
        PMODE_STOP = 2'h2
    } pmode_t;
    // Clock source options
    typedef enum logic [2:0] {
        CLKSRC_FAST_RC = 3'h0,
        CLKSRC_FAST_RC_RTC = 3'h1,
        CLKSRC_XTAL_HIGH = 3'h2,
        CLKSRC_XTAL_STD = 3'h3,
        CLKSRC_EXTERNAL = 3'h4
    } clksrc_t;
    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_HOLD = 5'b00001,
        ST_PWR_STAB = 5'b00010,
        ST_CLK_STAB = 5'b00100,
        ST_SW_PULSE = 5'b01000,
        ST_RUN = 5'b10000
    } seq_state_t;
endpackage

//--- tb/ext_reset_button.sv
// Model of an external reset push-button with a pull-up on the shared pin
`timescale 1ns/100ps
module ext_reset_button (
    // Clock
    input wire logic clk_sys_i,
    // Pin, low while the button is pressed
    output logic pin_n_o
);
    // A released button leaves the pin at the pull-up level
    initial pin_n_o = 1'b1;

    // Press for a number of cycles; called just after a rising edge
    task automatic press(input int cycles);
        pin_n_o <= 1'b0;
        repeat (cycles) @(posedge clk_sys_i);
        pin_n_o <= 1'b1;
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench of the reset and power-on controller
`timescale 1ns/100ps
module tb_top;
    import rst_ctrl_pkg::*;
    // Shortened counts so the run stays short
    localparam int PWR = 20;
    localparam int DEB = 10;
    localparam int SLOW = 4;
    // Oscillator ticks come on seven cycles of every eight
    localparam int SEQ_MIN = PWR + CLK_STAB_OSC * 8 / 7 + CLK_STAB_SLOW * SLOW - 10;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    detect_opt_t detect_opt_i = DETECT_LOW;
    pin_opt_t pin_opt_i = PIN_GPIO;
    wdog_opt_t wdog_opt_i = WDOG_DISABLE;
    logic [1:0] wdog_div_sel_i = 2'h0;
    clksrc_t clksrc_opt_i = CLKSRC_FAST_RC;
    logic [2:0] supply_le = 3'h0;
    pmode_t pmode_i = PMODE_NORMAL;
    logic osc_tick_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic cpu_rst_o;
    logic osc_start_o;
    logic osc_pins_gpio_o;
    logic shared_pin_gpio_o;
    logic shared_reset_pin_n_i;
    logic [15:0] fetch_addr_o;
    clksrc_t clksrc_o;
    int n_fail = 0;
    int samples_checked = 0;

    reset_power_on_controller #(.PWR_STAB_CYCLES(PWR), .DEBOUNCE_CYCLES(DEB),
        .SLOW_CYCLES(SLOW)) reset_power_on_controller_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .detect_opt_i(detect_opt_i),
        .pin_opt_i(pin_opt_i), .wdog_opt_i(wdog_opt_i), .wdog_div_sel_i(wdog_div_sel_i),
        .clksrc_opt_i(clksrc_opt_i), .supply_le_1v8_i(supply_le[0]),
        .supply_le_2v4_i(supply_le[1]), .supply_le_3v3_i(supply_le[2]),
        .shared_reset_pin_n_i(shared_reset_pin_n_i), .pmode_i(pmode_i),
        .osc_tick_i(osc_tick_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .cpu_rst_o(cpu_rst_o), .fetch_addr_o(fetch_addr_o), .clksrc_o(clksrc_o),
        .osc_start_o(osc_start_o), .osc_pins_gpio_o(osc_pins_gpio_o),
        .shared_pin_gpio_o(shared_pin_gpio_o));
    ext_reset_button ext_reset_button_inst (.clk_sys_i(clk_sys_i),
        .pin_n_o(shared_reset_pin_n_i));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and oscillator ticks with one gap in eight to keep the run short
    logic [2:0] tick_ph = 3'h0;
    initial forever #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        tick_ph <= tick_ph + 3'h1;
        osc_tick_i <= (tick_ph != 3'h7);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict; also the exit of an exhausted bus or wait_run wait
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bus cycle; the request stays up until waitrequest is seen low at an edge
    task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] d,
        output logic [31:0] q);
        int n;
        avs_address_i <= a;
        avs_read_i <= rd;
        avs_write_i <= !rd;
        avs_writedata_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        if (n >= 50) begin
            n_fail++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask
    // Release lets one edge pass so the next request never lands in the same step
    task automatic bus_idle();
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    // First cycle within n at which the core reset is seen, 0 if none
    task automatic watch(input int n, output int hit);
        hit = 0;
        for (int i = 1; i <= n && hit == 0; i++) begin
            @(posedge clk_sys_i);
            if (cpu_rst_o === 1'b1) hit = i;
        end
    endtask
    task automatic wait_run(output int n);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (cpu_rst_o !== 1'b0 && n < 9000);
        if (n >= 9000) begin
            n_fail++;
            finish_test();
        end
    endtask
    task automatic read_flags(output logic [31:0] q);
        bus(1'b1, ADDR_FLAGS, 8'h0, q);
        bus_idle();
    endtask
    // Full power-up with the given options
    task automatic por(input detect_opt_t d, input pin_opt_t p, input wdog_opt_t w,
        input clksrc_t c);
        int n;
        detect_opt_i <= d;
        pin_opt_i <= p;
        wdog_opt_i <= w;
        clksrc_opt_i <= c;
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        chk("oscillator idle in power phase", 0, osc_start_o);
        wait_run(n);
        chk("sequence not too short", 1, n + 10 >= SEQ_MIN);
        chk("sequence not too long", 1, n + 10 <= SEQ_MIN + 100);
        chk("oscillator started", 1, osc_start_o);
        chk("clock source", c, clksrc_o);
        chk("oscillator pins", c == CLKSRC_FAST_RC, osc_pins_gpio_o);
        chk("fetch address", RESET_VECTOR, fetch_addr_o);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int h;
        int n;
        int t;
        int m;
        logic [31:0] q;
        @(posedge clk_sys_i);
        // Registers and software reset; 1,0,1 cancels, a further 1 fires
        por(DETECT_LOW, PIN_GPIO, WDOG_DISABLE, CLKSRC_XTAL_STD);
        wr(ADDR_FLAGS, 8'hff);
        bus(1'b1, ADDR_FLAGS, 8'h0, q);
        chk("flags after write", 0, q);
        bus(1'b1, ADDR_SWRST, 8'h0, q);
        chk("software reset register", 0, q);
        bus(1'b1, 4'hc, 8'h0, q);
        chk("unmapped read", 0, q);
        wr(ADDR_SWRST, SWRST_KEY);
        wr(ADDR_SWRST, 8'h00);
        wr(ADDR_SWRST, SWRST_KEY);
        bus_idle();
        watch(20, h);
        chk("cancelled request", 0, h);
        wr(ADDR_SWRST, SWRST_KEY);
        fork bus_idle(); watch(4, h); join
        chk("software reset", 1, h > 0);
        wait_run(n);
        chk("short software pulse", 1, n <= 2);
        $display("test registers and software reset done");
        // Supply options, comparators falling one threshold at a time
        for (int o = 0; o < 4; o++) begin
            int r;
            detect_opt_t d;
            d = detect_opt_t'(o);
            r = (d == DETECT_MAXIMUM) ? 1 : (d == DETECT_HIGH) ? 2 : 3;
            por(d, PIN_GPIO, WDOG_DISABLE, CLKSRC_FAST_RC);
            for (int k = 1; k <= r; k++) begin
                supply_le <= (k == 1) ? 3'b100 : (k == 2) ? 3'b110 : 3'b111;
                watch(8, h);
                if (k < r) begin
                    chk("no supply reset", 0, h);
                    read_flags(q);
                    chk("mid flag", d == DETECT_MEDIUM && k >= 2, q[FLAG_MID_BIT]);
                    chk("high flag", d == DETECT_HIGH, q[FLAG_HIGH_BIT]);
                end else begin
                    chk("supply reset", 1, h > 0);
                end
            end
            supply_le <= 3'b000;
            wait_run(n);
            chk("supply reset sequence", 1, n > CLK_STAB_OSC);
            read_flags(q);
            chk("supply cause", 1, q[FLAG_SUPPLY_BIT]);
        end
        $display("test supply options done");
        // Reset pin: direct, de-bounced, and as general-purpose pin
        por(DETECT_LOW, PIN_RESET_DIRECT, WDOG_DISABLE, CLKSRC_EXTERNAL);
        chk("pin not gpio", 0, shared_pin_gpio_o);
        fork ext_reset_button_inst.press(6); join_none
        watch(3, h);
        chk("direct pin reset", 1, h > 0);
        wait_run(n);
        read_flags(q);
        chk("pin cause", 1, q[FLAG_PIN_BIT]);
        por(DETECT_LOW, PIN_RESET_DEBOUNCE, WDOG_DISABLE, CLKSRC_XTAL_HIGH);
        fork ext_reset_button_inst.press(DEB - 2); join_none
        watch(DEB + 10, h);
        chk("short press ignored", 0, h);
        fork ext_reset_button_inst.press(DEB + 5); join_none
        watch(DEB + 4, h);
        chk("long press resets", 1, h >= DEB && h <= DEB + 3);
        wait_run(n);
        por(DETECT_LOW, PIN_GPIO, WDOG_DISABLE, CLKSRC_FAST_RC);
        chk("pin as gpio", 1, shared_pin_gpio_o);
        fork ext_reset_button_inst.press(DEB + 5); join_none
        watch(DEB + 20, h);
        chk("gpio pin no reset", 0, h);
        $display("test reset pin done");
        // Watchdog always on: a clear holds it off, a wrong key does not
        for (int s = 0; s < 2; s++) begin
            t = WDT_TICKS * SLOW * (4 << s);
            m = 2 * SLOW * (4 << s) + 8;
            wdog_div_sel_i <= s[1:0];
            por(DETECT_LOW, PIN_GPIO, WDOG_ALWAYS, CLKSRC_FAST_RC_RTC);
            watch(t * 3 / 4, h);
            wr(ADDR_WDCLR, WDT_CLEAR_KEY);
            bus_idle();
            watch(t * 3 / 4, h);
            chk("no bite while cleared", 0, h);
            wr(ADDR_WDCLR, 8'h33);
            bus_idle();
            pmode_i <= (s == 1) ? PMODE_STOP : PMODE_IDLE;
            watch(t / 2, h);
            n = t * 3 / 4 + 2 + h;
            chk("bite period", 1, h > 0 && n >= t - m && n <= t + m);
            pmode_i <= PMODE_NORMAL;
            wait_run(n);
            read_flags(q);
            chk("watchdog cause", 1, q[FLAG_WDOG_BIT]);
        end
        // Enable option sleeps in idle; disable option never bites
        t = WDT_TICKS * SLOW * 4;
        wdog_div_sel_i <= 2'h0;
        por(DETECT_LOW, PIN_GPIO, WDOG_ENABLE, CLKSRC_FAST_RC);
        pmode_i <= PMODE_IDLE;
        watch(t + 500, h);
        chk("enable idle no bite", 0, h);
        pmode_i <= PMODE_NORMAL;
        watch(t + 500, h);
        chk("enable normal bites", 1, h > 0);
        wait_run(n);
        por(DETECT_LOW, PIN_GPIO, WDOG_DISABLE, CLKSRC_FAST_RC);
        watch(t + 500, h);
        chk("disabled never bites", 0, h);
        $display("test watchdog done");
        finish_test();
    end
endmodule
